/* hw/hoc_defines.vh */
// Constants for the harmonic overcurrent stage
`ifndef HOC_DEFINES_VH
`define HOC_DEFINES_VH

// Program cycle and tick
`define HOC_CYCLE_NS 5000000
`define HOC_CLK_NS 5
`define HOC_CYCLE_CLKS (`HOC_CYCLE_NS / `HOC_CLK_NS)

// Release at 97 percent of the pick-up level
`define HOC_RESET_NUM 7'h61
`define HOC_RESET_DEN 7'h64

// Register word offsets
`define HOC_A_CTRL 4'h0
`define HOC_A_PU_SET 4'h1
`define HOC_A_REL_SET 4'h2
`define HOC_A_DELAY 4'h3
`define HOC_A_RESET_T 4'h4
`define HOC_A_STATUS 4'h5
`define HOC_A_RATIO 4'h6
`define HOC_A_EXPECT 4'h7
`define HOC_A_REMAIN 4'h8

// Register reset values
`define HOC_PU_SET_RST 16'h0014
`define HOC_REL_SET_RST 16'h07D0
`define HOC_DELAY_RST 20'h00014
`define HOC_RESET_T_RST 20'h00000

// Monitoring mode select
`define HOC_MODE_PU 1'b0
`define HOC_MODE_REL 1'b1

// Channel select
`define HOC_CH_PHASE 2'h0
`define HOC_CH_RES1 2'h1
`define HOC_CH_RES2 2'h2

// Harmonic index select: 2..7, 9, 11, 13, 15, 17, 19
`define HOC_HARM_DEFAULT 4'h0
`define HOC_HARM_COUNT 12

// Condition and force codes
`define HOC_ST_NORMAL 2'h0
`define HOC_ST_START 2'h1
`define HOC_ST_TRIP 2'h2
`define HOC_ST_BLOCKED 2'h3

// Delay curve select
`define HOC_CURVE_DT 1'b0
`define HOC_CURVE_INVERSE_MINIMUM_TIME_CURVE 1'b1

`endif

/* hw/hoc_phase_cmp.v */
// Per-phase magnitude compare with hysteresis and live ratio
`timescale 1ns/1ps
`include "hoc_defines.vh"

module hoc_phase_cmp #(
    parameter W = 16
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_rst_n,
    // Evaluation
    input wire i_eval,
    input wire [W-1:0] i_measured_magnitude,
    input wire [W-1:0] i_harmonic_pickup_level,
    // Results
    output reg o_picked_up,
    output reg [W-1:0] o_ratio
);

    wire [W+6:0] mag_x100;
    wire [W+6:0] set_x100;
    wire [W+6:0] set_x97;
    wire [W+6:0] ratio_full;

    assign mag_x100 = i_measured_magnitude * `HOC_RESET_DEN;
    assign set_x100 = i_harmonic_pickup_level * `HOC_RESET_DEN;
    assign set_x97 = i_harmonic_pickup_level * `HOC_RESET_NUM;
    // Ratio in hundredths; zero level guarded to avoid a divide by zero
    assign ratio_full = (i_harmonic_pickup_level == {W{1'b0}}) ? {(W+7){1'b1}} :
                        mag_x100 / {7'h00, i_harmonic_pickup_level};

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_picked_up <= 1'b0;
            o_ratio <= {W{1'b0}};
        end else if (i_eval) begin
            o_ratio <= (ratio_full[W+6:W] != 7'h00) ? {W{1'b1}} : ratio_full[W-1:0];
            if (!o_picked_up && mag_x100 > set_x100) begin
                o_picked_up <= 1'b1;
            end else if (o_picked_up && mag_x100 < set_x97) begin
                o_picked_up <= 1'b0;
            end
        end
    end

endmodule // hoc_phase_cmp

/* hw/harmonic_overcurrent_stage.v */
// Harmonic overcurrent stage decision logic
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "hoc_defines.vh"

module harmonic_overcurrent_stage #(
    parameter W = 16,
    parameter TW = 20,
    parameter CYCLE_CLKS = `HOC_CYCLE_CLKS
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_rst_n,
    // Measurements: 12 harmonics of W bits, lowest index in low bits
    input wire i_meas_valid,
    input wire [W-1:0] i_phase_a_fund,
    input wire [W-1:0] i_phase_b_fund,
    input wire [W-1:0] i_phase_c_fund,
    input wire [W-1:0] i_res1_fund,
    input wire [W-1:0] i_res2_fund,
    input wire [12*W-1:0] i_phase_a_harm,
    input wire [12*W-1:0] i_phase_b_harm,
    input wire [12*W-1:0] i_phase_c_harm,
    input wire [12*W-1:0] i_res1_harm,
    input wire [12*W-1:0] i_res2_harm,
    // Blocking matrix pin
    input wire i_block,
    // Register port
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // Stage outputs
    output wire o_start,
    output wire o_trip,
    output wire o_blocked,
    output wire [1:0] o_condition,
    // Events: one-cycle pulses and the stamp of the latest change
    output reg o_start_on,
    output reg o_start_off,
    output reg o_trip_on,
    output reg o_trip_off,
    output reg o_block_on,
    output reg o_block_off,
    output reg [31:0] o_event_stamp
);

    ////////////////////////////////////////////////////////////////////////
    // Register map (word index)
    localparam [3:0] A_CTRL = `HOC_A_CTRL;
    localparam [3:0] A_PU_SET = `HOC_A_PU_SET;
    localparam [3:0] A_REL_SET = `HOC_A_REL_SET;
    localparam [3:0] A_DELAY = `HOC_A_DELAY;
    localparam [3:0] A_RESET_T = `HOC_A_RESET_T;
    localparam [3:0] A_STATUS = `HOC_A_STATUS;
    localparam [3:0] A_RATIO = `HOC_A_RATIO;
    localparam [3:0] A_EXPECT = `HOC_A_EXPECT;
    localparam [3:0] A_REMAIN = `HOC_A_REMAIN;

    // Control register: mode[0], curve[1], ch[3:2], harm[7:4], force en[8], force[10:9]
    reg mode_r;
    reg curve_r;
    reg [1:0] chan_r;
    reg [3:0] harm_r;
    reg force_en_r;
    reg [1:0] force_r;
    reg [W-1:0] pu_set_r;
    reg [W-1:0] rel_set_r;
    reg [TW-1:0] delay_r;
    reg [TW-1:0] reset_t_r;

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mode_r <= `HOC_MODE_PU;
            curve_r <= `HOC_CURVE_DT;
            chan_r <= `HOC_CH_PHASE;
            harm_r <= `HOC_HARM_DEFAULT;
            force_en_r <= 1'b0;
            force_r <= `HOC_ST_NORMAL;
            pu_set_r <= `HOC_PU_SET_RST;
            rel_set_r <= `HOC_REL_SET_RST;
            delay_r <= `HOC_DELAY_RST;
            reset_t_r <= `HOC_RESET_T_RST;
        end else if (i_wr) begin
            // Writes land at once; the next evaluation uses them
            case (i_addr)
                A_CTRL: begin
                    mode_r <= i_wdata[0];
                    curve_r <= i_wdata[1];
                    chan_r <= (i_wdata[3:2] == 2'h3) ? `HOC_CH_PHASE : i_wdata[3:2];
                    harm_r <= (i_wdata[7:4] > 4'hB) ? `HOC_HARM_DEFAULT : i_wdata[7:4];
                    force_en_r <= i_wdata[8];
                    force_r <= i_wdata[10:9];
                end
                A_PU_SET: pu_set_r <= i_wdata[W-1:0];
                A_REL_SET: rel_set_r <= i_wdata[W-1:0];
                A_DELAY: delay_r <= i_wdata[TW-1:0];
                A_RESET_T: reset_t_r <= i_wdata[TW-1:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program cycle tick
    reg [22:0] tick_cnt_r;
    wire tick;
    assign tick = (tick_cnt_r == CYCLE_CLKS - 1);

    always @(posedge i_mclk) begin
        if (!i_rst_n || tick) begin
            tick_cnt_r <= 23'h000000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 23'h000001;
        end
    end

    // Block pin synchroniser
    reg blk_s1_r;
    reg blk_s2_r;
    reg blk_r;
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            blk_s1_r <= 1'b0;
            blk_s2_r <= 1'b0;
            blk_r <= 1'b0;
        end else begin
            blk_s1_r <= i_block;
            blk_s2_r <= blk_s1_r;
            if (tick) begin
                blk_r <= blk_s2_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel and harmonic selection, mode scaling
    wire [5*W-1:0] fund_bus;
    wire [5*12*W-1:0] harm_bus;
    assign fund_bus = {i_res2_fund, i_res1_fund, i_phase_c_fund, i_phase_b_fund, i_phase_a_fund};
    assign harm_bus = {i_res2_harm, i_res1_harm, i_phase_c_harm, i_phase_b_harm, i_phase_a_harm};

    wire [3*W-1:0] mag_bus;
    wire [2:0] pick_vec;
    wire [3*W-1:0] ratio_bus;
    wire [W-1:0] level;
    // Relative level is in hundredths of a percent, magnitude scaled to match
    assign level = mode_r ? rel_set_r : pu_set_r;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ph
            // Residual modes feed the one residual channel into all three slots
            localparam integer PH = g;
            wire [2:0] src;
            wire [W-1:0] h;
            wire [W-1:0] f;
            wire [W+13:0] rel;
            assign src = (chan_r == `HOC_CH_PHASE) ? PH[2:0] :
                         (chan_r == `HOC_CH_RES1) ? 3'h3 : 3'h4;
            assign h = harm_bus[(src*12 + harm_r)*W +: W];
            assign f = fund_bus[src*W +: W];
            assign rel = (f == {W{1'b0}}) ? {(W+14){1'b0}} :
                         (h * 14'd10000) / {14'h0000, f};
            assign mag_bus[g*W +: W] = !mode_r ? h :
                         ((rel[W+13:W] != 14'h0000) ? {W{1'b1}} : rel[W-1:0]);
            hoc_phase_cmp #(
                .W(W)
            ) u_cmp (
                .i_mclk(i_mclk),
                .i_rst_n(i_rst_n),
                .i_eval(tick && i_meas_valid),
                .i_measured_magnitude(mag_bus[g*W +: W]),
                .i_harmonic_pickup_level(level),
                .o_picked_up(pick_vec[g]),
                .o_ratio(ratio_bus[g*W +: W])
            );
        end
    endgenerate

    wire pickup;
    assign pickup = |pick_vec;

    // Largest phase ratio for display
    reg [W-1:0] max_ratio;
    integer k;
    always @* begin
        max_ratio = {W{1'b0}};
        for (k = 0; k < 3; k = k + 1) begin
            if (ratio_bus[k*W +: W] > max_ratio) begin
                max_ratio = ratio_bus[k*W +: W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operating time: counts of program cycles
    // Inverse curve: delay scaled by 100/ratio, ceiling at delay setting
    wire [TW+6:0] inverse_minimum_time_curve_full;
    wire [TW-1:0] expect_t;
    assign inverse_minimum_time_curve_full = (max_ratio <= 16'h0064) ? {7'h00, delay_r} :
                       ({7'h00, delay_r} * 27'd100) / {{(TW+7-W){1'b0}}, max_ratio};
    assign expect_t = (curve_r == `HOC_CURVE_INVERSE_MINIMUM_TIME_CURVE) ?
                      ((inverse_minimum_time_curve_full[TW+6:TW] != 7'h00) ? {TW{1'b1}} : inverse_minimum_time_curve_full[TW-1:0]) :
                      delay_r;

    // Stage states
    localparam [3:0] S_NORMAL = 4'b0001;
    localparam [3:0] S_START = 4'b0010;
    localparam [3:0] S_TRIP = 4'b0100;
    localparam [3:0] S_BLOCKED = 4'b1000;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [TW-1:0] remain_r;
    reg [TW-1:0] rel_cnt_r;
    reg [TW-1:0] expect_r;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_NORMAL: begin
                if (pickup && blk_r) begin
                    state_nxt = S_BLOCKED;
                end else if (pickup) begin
                    state_nxt = S_START;
                end
            end
            S_START: begin
                if (blk_r || !pickup) begin
                    state_nxt = pickup ? S_BLOCKED : S_NORMAL;
                end else if (remain_r <= 20'h00001) begin
                    state_nxt = S_TRIP;
                end
            end
            S_TRIP: begin
                if (!pickup && rel_cnt_r == 20'h00000) begin
                    state_nxt = S_NORMAL;
                end
            end
            S_BLOCKED: begin
                if (!pickup) begin
                    state_nxt = S_NORMAL;
                end else if (!blk_r) begin
                    state_nxt = S_START;
                end
            end
            default: state_nxt = S_NORMAL;
        endcase
    end

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_r <= S_NORMAL;
            remain_r <= 20'h00000;
            rel_cnt_r <= 20'h00000;
            expect_r <= 20'h00000;
        end else if (tick) begin
            state_r <= state_nxt;
            expect_r <= expect_t;
            if (state_nxt == S_START && state_r == S_START) begin
                remain_r <= (remain_r > expect_t) ? expect_t - 20'h00001 :
                            remain_r - 20'h00001;
            end else begin
                remain_r <= expect_t;
            end
            // Release timer runs whenever pick-up is lost
            if (pickup) begin
                rel_cnt_r <= reset_t_r;
            end else if (rel_cnt_r != 20'h00000) begin
                rel_cnt_r <= rel_cnt_r - 20'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Forced status overrides the outputs only
    reg [1:0] cond;
    always @* begin
        case (state_r)
            S_START: cond = `HOC_ST_START;
            S_TRIP: cond = `HOC_ST_TRIP;
            S_BLOCKED: cond = `HOC_ST_BLOCKED;
            default: cond = `HOC_ST_NORMAL;
        endcase
        if (force_en_r) begin
            cond = force_r;
        end
    end

    assign o_condition = cond;
    assign o_start = (cond == `HOC_ST_START);
    assign o_trip = (cond == `HOC_ST_TRIP);
    assign o_blocked = (cond == `HOC_ST_BLOCKED);

    // Events with free-running stamp in program cycles
    reg [31:0] stamp_r;
    reg [2:0] prev_r;
    wire [2:0] now_v;
    assign now_v = {o_blocked, o_trip, o_start};

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            stamp_r <= 32'h00000000;
            prev_r <= 3'h0;
            o_start_on <= 1'b0;
            o_start_off <= 1'b0;
            o_trip_on <= 1'b0;
            o_trip_off <= 1'b0;
            o_block_on <= 1'b0;
            o_block_off <= 1'b0;
            o_event_stamp <= 32'h00000000;
        end else begin
            if (tick) begin
                stamp_r <= stamp_r + 32'h00000001;
            end
            prev_r <= now_v;
            o_start_on <= now_v[0] & ~prev_r[0];
            o_start_off <= ~now_v[0] & prev_r[0];
            o_trip_on <= now_v[1] & ~prev_r[1];
            o_trip_off <= ~now_v[1] & prev_r[1];
            o_block_on <= now_v[2] & ~prev_r[2];
            o_block_off <= ~now_v[2] & prev_r[2];
            if (now_v != prev_r) begin
                o_event_stamp <= stamp_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                A_CTRL: o_rdata <= {21'h000000, force_r, force_en_r, harm_r, chan_r,
                                    curve_r, mode_r};
                A_PU_SET: o_rdata <= {{(32-W){1'b0}}, pu_set_r};
                A_REL_SET: o_rdata <= {{(32-W){1'b0}}, rel_set_r};
                A_DELAY: o_rdata <= {{(32-TW){1'b0}}, delay_r};
                A_RESET_T: o_rdata <= {{(32-TW){1'b0}}, reset_t_r};
                A_STATUS: o_rdata <= {29'h00000000, blk_r, cond};
                A_RATIO: o_rdata <= {{(32-W){1'b0}}, max_ratio};
                A_EXPECT: o_rdata <= {{(32-TW){1'b0}}, expect_r};
                A_REMAIN: o_rdata <= (state_r == S_START) ?
                                     {{(32-TW){1'b0}}, remain_r} : 32'h00000000;
                default: o_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule // harmonic_overcurrent_stage

/* verif/hoc_front_end.sv */
// Harmonic measurement front end model
`timescale 1ns/1ps

module hoc_front_end #(
    parameter W = 16,
    parameter PERIOD = 20
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_rst_n,
    // Wanted magnitudes; chan mask is a, b, c, res1, res2
    input wire [W-1:0] i_set_mag,
    input wire [W-1:0] i_set_fund,
    input wire [3:0] i_set_idx,
    input wire [4:0] i_set_chan,
    // Delivered measurements
    output reg o_meas_valid = 1'b0,
    output reg [W-1:0] o_fund = '0,
    output reg [12*W-1:0] o_harm_a = '0,
    output reg [12*W-1:0] o_harm_b = '0,
    output reg [12*W-1:0] o_harm_c = '0,
    output reg [12*W-1:0] o_harm_r1 = '0,
    output reg [12*W-1:0] o_harm_r2 = '0
);
    reg [31:0] cnt_r;
    reg [12*W-1:0] slot;
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cnt_r <= 32'h0;
            o_meas_valid <= 1'b0;
        end else if (cnt_r == PERIOD - 1) begin
            cnt_r <= 32'h0;
            slot = '0;
            slot[i_set_idx*W +: W] = i_set_mag;
            o_meas_valid <= 1'b1;
            o_fund <= i_set_fund;
            o_harm_a <= i_set_chan[0] ? slot : '0;
            o_harm_b <= i_set_chan[1] ? slot : '0;
            o_harm_c <= i_set_chan[2] ? slot : '0;
            o_harm_r1 <= i_set_chan[3] ? slot : '0;
            o_harm_r2 <= i_set_chan[4] ? slot : '0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule // hoc_front_end

/* verif/hoc_checker.sv */
// Assertion checker for the harmonic overcurrent stage
`timescale 1ns/1ps
`include "hoc_defines.vh"

module hoc_checker #(
    parameter CYCLE_CLKS = 20
) (
    input wire i_mclk,
    input wire i_rst_n,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [31:0] o_rdata,
    input wire o_start,
    input wire o_trip,
    input wire o_blocked,
    input wire [1:0] o_condition,
    input wire o_start_on,
    input wire o_start_off,
    input wire o_trip_on,
    input wire o_trip_off,
    input wire o_block_on,
    input wire o_block_off,
    input wire [31:0] o_event_stamp
);
    // Forcing is sticky here so forced jumps never look like faults
    reg forced_r;
    reg inverse_minimum_time_curve_r;
    reg [31:0] delay_r;
    reg [31:0] start_cnt_r;
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            forced_r <= 1'b0;
            inverse_minimum_time_curve_r <= 1'b0;
            delay_r <= 32'h14;
            start_cnt_r <= 32'h0;
        end else begin
            if (i_wr && i_addr == 4'h0) begin
                forced_r <= forced_r | i_wdata[8];
                inverse_minimum_time_curve_r <= i_wdata[1];
            end
            if (i_wr && i_addr == 4'h3) begin
                delay_r <= i_wdata;
            end
            start_cnt_r <= o_start ? start_cnt_r + 32'h1 : 32'h0;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence start_rise;
        !o_start ##1 o_start;
    endsequence
    sequence trip_rise;
        !o_trip ##1 o_trip;
    endsequence
    cond_decode_a: assert property (o_start == (o_condition == `HOC_ST_START)
        && o_trip == (o_condition == `HOC_ST_TRIP) && o_blocked == (o_condition == `HOC_ST_BLOCKED))
        else $error("condition and outputs disagree");
    start_on_a: assert property (start_rise |=> o_start_on)
        else $error("start on event missing");
    start_off_a: assert property ($fell(o_start) |=> o_start_off)
        else $error("start off event missing");
    trip_on_a: assert property (trip_rise |=> o_trip_on)
        else $error("trip on event missing");
    block_on_a: assert property ($rose(o_blocked) |=> o_block_on)
        else $error("block on event missing");
    trip_off_a: assert property ($fell(o_trip) |=> o_trip_off)
        else $error("trip off event missing");
    block_off_a: assert property ($fell(o_blocked) |=> o_block_off)
        else $error("block off event missing");
    // State moves once per tick at most, so every unforced event gets a newer stamp
    stamp_order_a: assert property (disable iff (!i_rst_n || forced_r)
        (o_start_on || o_start_off || o_trip_on || o_trip_off || o_block_on || o_block_off)
        |-> o_event_stamp > $past(o_event_stamp)) else $error("event stamp did not advance");
    event_cause_a: assert property (o_start_on |-> $past(o_start) && !$past(o_start, 2))
        else $error("start on event without start rise");
    trip_after_start_a: assert property (disable iff (!i_rst_n || forced_r)
        trip_rise |-> $past(o_start)) else $error("trip without start");
    trip_delay_a: assert property (disable iff (!i_rst_n || forced_r || inverse_minimum_time_curve_r)
        trip_rise |-> start_cnt_r == delay_r * CYCLE_CLKS) else $error("trip delay wrong");
    rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved without read");
endmodule // hoc_checker

bind harmonic_overcurrent_stage hoc_checker #(.CYCLE_CLKS(CYCLE_CLKS)) u_hoc_checker (
    .i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_start, .o_trip,
    .o_blocked, .o_condition, .o_start_on, .o_start_off, .o_trip_on, .o_trip_off,
    .o_block_on, .o_block_off, .o_event_stamp
);

/* verif/tb_top.sv */
// Self-checking testbench for the harmonic overcurrent stage
`timescale 1ns/1ps
`include "hoc_defines.vh"

module tb_top;
    localparam W = 16;
    localparam CYC = 20;
    reg i_mclk = 1'b0;
    reg i_rst_n = 1'b0;
    reg i_block = 1'b0;
    reg [3:0] i_addr = 4'h0;
    reg [31:0] i_wdata = 32'h0;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg [W-1:0] set_mag = 16'h0;
    reg [W-1:0] set_fund = 16'h64;
    reg [3:0] set_idx = 4'h0;
    reg [4:0] set_chan = 5'h07;
    wire meas_valid;
    wire [W-1:0] fund;
    wire [12*W-1:0] harm_a, harm_b, harm_c, harm_r1, harm_r2;
    wire [31:0] o_rdata;
    wire [1:0] o_condition;
    wire o_start, o_trip, o_blocked;
    logic [31:0] exp_q[$];
    logic [31:0] rst_vals [0:9] = '{32'h0, 32'h14, 32'h7D0, 32'h14, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0};
    logic rd_q = 1'b0;
    int n_fail = 0;
    int total_checks = 0;
    int mag;
    int k;

    hoc_front_end #(.W(W), .PERIOD(CYC)) u_hoc_front_end (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_set_mag(set_mag), .i_set_fund(set_fund),
        .i_set_idx(set_idx), .i_set_chan(set_chan), .o_meas_valid(meas_valid), .o_fund(fund),
        .o_harm_a(harm_a), .o_harm_b(harm_b), .o_harm_c(harm_c), .o_harm_r1(harm_r1),
        .o_harm_r2(harm_r2)
    );
    harmonic_overcurrent_stage #(.W(W), .CYCLE_CLKS(CYC)) u_harmonic_overcurrent_stage (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_meas_valid(meas_valid),
        .i_phase_a_fund(fund), .i_phase_b_fund(fund), .i_phase_c_fund(fund),
        .i_res1_fund(fund), .i_res2_fund(fund), .i_phase_a_harm(harm_a),
        .i_phase_b_harm(harm_b), .i_phase_c_harm(harm_c), .i_res1_harm(harm_r1),
        .i_res2_harm(harm_r2), .i_block(i_block), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_start(o_start), .o_trip(o_trip),
        .o_blocked(o_blocked), .o_condition(o_condition), .o_start_on(), .o_start_off(),
        .o_trip_on(), .o_trip_off(), .o_block_on(), .o_block_off(), .o_event_stamp()
    );
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
        total_checks++;
        if (seen !== expv) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, expv, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic wait_cond(input logic [1:0] c);
        int t;
        t = 0;
        while (o_condition !== c && t < 60 * CYC) begin
            @(posedge i_mclk);
            t++;
        end
        chk("condition", {30'h0, o_condition}, {30'h0, c});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Read data are checked in the cycle after the strobe; they hold until the next read
    always @(posedge i_mclk) begin
        if (rd_q)
            chk("rdata", o_rdata, exp_q.pop_front());
        rd_q <= i_rd;
    end
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
    ////////////////////////////////////////
    initial begin
        k = $urandom(62);
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        wr(4'h9, 32'hFFFF);
        for (k = 0; k < 10; k++) begin
            if (k != 7)
                rd(k[3:0], rst_vals[k]);
        end
        wr(4'h0, 32'h000000FC);
        rd(4'h0, 32'h0);
        for (k = 0; k < 12; k++) begin
            mag = $urandom_range(21, 60);
            wr(4'h0, {24'h0, k[3:0], 4'h0});
            set_idx <= k[3:0];
            set_mag <= mag[15:0];
            set_chan <= 5'h01 << (k % 3);
            wait_cond(`HOC_ST_START);
            rd(4'h6, 32'(mag * 5));
            rd(4'h8, 32'h14);
            rd(4'h7, 32'h14);
            set_mag <= 16'h0;
            wait_cond(`HOC_ST_NORMAL);
        end
        // Residual selected: phase harmonics must be ignored
        for (k = 1; k < 3; k++) begin
            wr(4'h0, {28'h0, k[1:0], 2'b00});
            set_idx <= 4'h0;
            set_chan <= 5'h07;
            set_mag <= 16'h30;
            repeat (4 * CYC) @(posedge i_mclk);
            rd(4'h5, 32'h0);
            set_chan <= (k == 1) ? 5'h08 : 5'h10;
            wait_cond(`HOC_ST_START);
            set_mag <= 16'h0;
            wait_cond(`HOC_ST_NORMAL);
        end
        wr(4'h0, 32'h1);
        set_chan <= 5'h07;
        set_mag <= 16'h15;
        wait_cond(`HOC_ST_START);
        set_mag <= 16'h13;
        wait_cond(`HOC_ST_NORMAL);
        wr(4'h0, 32'h0);
        wr(4'h3, 32'h3);
        wr(4'h4, 32'h1);
        set_mag <= 16'h15;
        wait_cond(`HOC_ST_START);
        wait_cond(`HOC_ST_TRIP);
        set_mag <= 16'h14;
        repeat (5 * CYC) @(posedge i_mclk);
        rd(4'h5, 32'h2);
        set_mag <= 16'h13;
        wait_cond(`HOC_ST_NORMAL);
        wr(4'h3, 32'h14);
        set_mag <= 16'h30;
        wait_cond(`HOC_ST_START);
        repeat (CYC) @(posedge i_mclk);
        rd(4'h8, 32'h13);
        i_block <= 1'b1;
        wait_cond(`HOC_ST_BLOCKED);
        rd(4'h5, 32'h7);
        rd(4'h8, 32'h0);
        set_mag <= 16'h0;
        wait_cond(`HOC_ST_NORMAL);
        set_mag <= 16'h30;
        wait_cond(`HOC_ST_BLOCKED);
        i_block <= 1'b0;
        wait_cond(`HOC_ST_START);
        set_mag <= 16'h0;
        wait_cond(`HOC_ST_NORMAL);
        wr(4'h0, 32'h2);
        set_mag <= 16'h1E;
        wait_cond(`HOC_ST_START);
        rd(4'h7, 32'hD);
        wr(4'h1, 32'h40);
        wait_cond(`HOC_ST_NORMAL);
        set_mag <= 16'h0;
        wr(4'h0, 32'h400);
        chk("force off", {30'h0, o_condition}, 32'h0);
        for (k = 0; k < 4; k++) begin
            wr(4'h0, {21'h0, k[1:0], 9'h100});
            chk("forced", {30'h0, o_condition}, 32'(k));
        end
        test_done();
    end
endmodule // tb_top
